// [core/ppm_mux.sv]
// Behaviour
// - Mode 00/11 with select 1: host port
// - Mode 01/10 with select 1: floppy pins
// - Select 0: embedded controller owns pins
// - Host port controls act on pins
// - Host powerdown state decides pin state
// - Floppy powerdown state decides pin state
// - Controller pins driven unless supply-good low
// - Not owner: data reads last write
// - Not owner: control reads cable absent
// - Not owner: status reads cable absent
// - Controller port-enable acts only for host
// - Floppy ownership denies host the port
// - Floppy outputs open drain, 14 mA
// - PD0-PD4 are floppy drive inputs
// - Floppy outputs map onto fixed pins
// - Single drive keeps one swapped pair
module ppm_mux
    import ppm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] device_mode,
    input wire logic host_access_select,
    input wire logic main_supply_good,
    input wire logic drive_swap,
    input wire logic fdc_activate,
    input wire logic fdc_powerdown,
    input wire logic host_activate,
    input wire logic host_powerdown,
    input wire logic ec_port_enable,
    input wire ppm_pins_t host_out,
    input wire ppm_pins_t host_oe,
    input wire logic host_data_write,
    input wire logic [7:0] host_data_wdata,
    input wire logic [7:0] host_data_native,
    input wire logic [7:0] host_ctrl_native,
    input wire logic [7:0] host_status_native,
    input wire ppm_fdc_out_t fdc_out,
    input wire ppm_pins_t ec_out,
    input wire ppm_pins_t ec_oe,
    input wire ppm_pins_t port_physical_pins_in,
    output ppm_pins_t port_physical_pins_out,
    output ppm_pins_t port_physical_pins_oe,
    output ppm_owner_t owner,
    output logic host_denied,
    output logic host_not_owner,
    output logic [7:0] host_data_rdata,
    output logic [7:0] host_ctrl_rdata,
    output logic [7:0] host_status_rdata,
    output ppm_fdc_in_t fdc_in,
    output ppm_pins_t ec_in
);

    ppm_pins_t pin_sync;
    logic supply_sync;
    logic mode_host;
    logic mode_single;
    ppm_owner_t next_owner;
    logic host_live;
    logic fdc_live;
    logic ec_live;
    ppm_pins_t fdc_sink_oe;
    ppm_fdc_in_t fdc_in_map;
    ppm_pins_t next_pin_out;
    ppm_pins_t next_pin_oe;
    logic [7:0] data_shadow;
    logic [7:0] next_data_rd;
    logic [7:0] next_ctrl_rd;
    logic [7:0] next_stat_rd;

    ppm_sync #(.W(PIN_COUNT)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .d(port_physical_pins_in),
        .q(pin_sync)
    );

    ppm_sync #(.W(1)) u_supply_sync (
        .clk(clk),
        .rst(rst),
        .d(main_supply_good),
        .q(supply_sync)
    );

    assign mode_host = (device_mode == MODE_HOST_LO) || (device_mode == MODE_HOST_HI);
    assign mode_single = (device_mode == MODE_FDC_SINGLE);
    assign next_owner = !host_access_select ? PPM_OWN_EC :
                        mode_host ? PPM_OWN_HOST :
                        PPM_OWN_FDC;

    // The controller's port-enable gates only the host owner.
    assign host_live = (next_owner == PPM_OWN_HOST) && host_activate && !host_powerdown
                       && ec_port_enable;
    assign fdc_live = (next_owner == PPM_OWN_FDC) && fdc_activate && !fdc_powerdown;
    assign ec_live = (next_owner == PPM_OWN_EC) && supply_sync;

    ppm_fdc_map u_fdc_map (
        .fdc_out(fdc_out),
        .enable(fdc_live),
        .single(mode_single),
        .drive_swap(drive_swap),
        .pin_sync(pin_sync),
        .sink_oe(fdc_sink_oe),
        .fdc_in(fdc_in_map)
    );

    assign next_pin_out = host_live ? host_out :
                          ec_live ? ec_out : PINS_ZERO;
    assign next_pin_oe = host_live ? host_oe :
                         ec_live ? ec_oe :
                         fdc_live ? fdc_sink_oe : PINS_ZERO;

    assign next_data_rd = (next_owner == PPM_OWN_HOST) ? host_data_native : data_shadow;
    assign next_ctrl_rd = (next_owner == PPM_OWN_HOST) ? host_ctrl_native :
                          ((host_ctrl_native & CTRL_KEEP_MASK) | CTRL_NO_CABLE);
    assign next_stat_rd = (next_owner == PPM_OWN_HOST) ? host_status_native :
                          ((host_status_native & STAT_KEEP_MASK) | STAT_NO_CABLE);

    // The shadow follows every write so read-back is right after a handover.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_shadow <= 8'h00;
        end else if (host_data_write) begin
            data_shadow <= host_data_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            owner <= PPM_OWN_EC;
            host_denied <= 1'b0;
            host_not_owner <= 1'b1;
        end else begin
            owner <= next_owner;
            host_denied <= (next_owner == PPM_OWN_FDC);
            host_not_owner <= (next_owner != PPM_OWN_HOST);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port_physical_pins_out <= PINS_ZERO;
            port_physical_pins_oe <= PINS_ZERO;
        end else begin
            port_physical_pins_out <= next_pin_out;
            port_physical_pins_oe <= next_pin_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_data_rdata <= 8'h00;
            host_ctrl_rdata <= CTRL_NO_CABLE;
            host_status_rdata <= STAT_NO_CABLE;
            fdc_in <= '1;
            ec_in <= PINS_ZERO;
        end else begin
            host_data_rdata <= next_data_rd;
            host_ctrl_rdata <= next_ctrl_rd;
            host_status_rdata <= next_stat_rd;
            fdc_in <= fdc_in_map;
            ec_in <= pin_sync;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_owner_ec;
        !host_access_select |=> owner == PPM_OWN_EC;
    endproperty
    a_owner_ec: assert property (p_owner_ec) else $error("select low did not give controller ownership");

    property p_owner_host;
        host_access_select && (device_mode == 2'h0 || device_mode == 2'h3) |=> owner == PPM_OWN_HOST;
    endproperty
    a_owner_host: assert property (p_owner_host) else $error("host mode did not give host ownership");

    property p_owner_fdc;
        host_access_select && (device_mode == 2'h1 || device_mode == 2'h2) |=> owner == PPM_OWN_FDC && host_denied;
    endproperty
    a_owner_fdc: assert property (p_owner_fdc) else $error("floppy mode did not give floppy ownership");

    property p_host_powerdown;
        host_access_select && mode_host && host_powerdown |=> port_physical_pins_oe == PINS_ZERO;
    endproperty
    a_host_powerdown: assert property (p_host_powerdown) else $error("pins driven in host powerdown");

    property p_fdc_open_drain;
        owner == PPM_OWN_FDC |-> (port_physical_pins_out == PINS_ZERO) && !port_physical_pins_oe.pd[0];
    endproperty
    a_fdc_open_drain: assert property (p_fdc_open_drain) else $error("floppy pin driven high or input driven");

    property p_fdc_powerdown;
        host_access_select && !mode_host && fdc_powerdown |=> port_physical_pins_oe == PINS_ZERO;
    endproperty
    a_fdc_powerdown: assert property (p_fdc_powerdown) else $error("pins driven in floppy powerdown");

    property p_ec_supply;
        (!host_access_select && !main_supply_good) [*3] |=> port_physical_pins_oe == PINS_ZERO;
    endproperty
    a_ec_supply: assert property (p_ec_supply) else $error("controller pins driven without supply");

    property p_ec_driven;
        (!host_access_select && main_supply_good) [*3] |=> port_physical_pins_oe == $past(ec_oe);
    endproperty
    a_ec_driven: assert property (p_ec_driven) else $error("controller pins not driven");

    property p_data_shadow;
        host_data_write ##1 (!host_data_write && !host_access_select) |=> host_data_rdata == $past(host_data_wdata, 2);
    endproperty
    a_data_shadow: assert property (p_data_shadow) else $error("data read-back is not the last write");

    property p_ctrl_cable;
        owner != PPM_OWN_HOST |-> host_ctrl_rdata[3:0] == 4'h4 && host_status_rdata[7:3] == 5'h09;
    endproperty
    a_ctrl_cable: assert property (p_ctrl_cable) else $error("read-back does not show cable absent");

    property p_port_enable;
        host_access_select && mode_host && !ec_port_enable |=> port_physical_pins_oe == PINS_ZERO;
    endproperty
    a_port_enable: assert property (p_port_enable) else $error("port-enable off but host pins driven");

    property p_single_pair;
        host_access_select && device_mode == 2'h1 && !drive_swap |=> !port_physical_pins_oe.strobe
            && !port_physical_pins_oe.pd[6];
    endproperty
    a_single_pair: assert property (p_single_pair) else $error("inactive drive pair driven");

    property p_host_pins;
        host_access_select && mode_host && host_activate && !host_powerdown && ec_port_enable
            |=> port_physical_pins_out == $past(host_out) && port_physical_pins_oe == $past(host_oe);
    endproperty
    a_host_pins: assert property (p_host_pins) else $error("host port values do not reach the pins");

    property p_host_inactive;
        host_access_select && mode_host && !host_activate |=> port_physical_pins_oe == PINS_ZERO;
    endproperty
    a_host_inactive: assert property (p_host_inactive) else $error("pins driven by inactive host port");

    property p_fdc_inactive;
        host_access_select && !mode_host && !fdc_activate |=> port_physical_pins_oe == PINS_ZERO;
    endproperty
    a_fdc_inactive: assert property (p_fdc_inactive) else $error("pins driven by inactive floppy");

    property p_host_reads;
        host_access_select && mode_host |=> host_data_rdata == $past(host_data_native)
            && host_ctrl_rdata == $past(host_ctrl_native) && host_status_rdata == $past(host_status_native);
    endproperty
    a_host_reads: assert property (p_host_reads) else $error("host owner does not read its registers");

    // Only the cable bits are forced; the rest of each register still reads through.
    property p_cable_keep;
        !host_access_select || !mode_host
            |=> (host_ctrl_rdata & CTRL_KEEP_MASK) == ($past(host_ctrl_native) & CTRL_KEEP_MASK)
            && (host_status_rdata & STAT_KEEP_MASK) == ($past(host_status_native) & STAT_KEEP_MASK);
    endproperty
    a_cable_keep: assert property (p_cable_keep) else $error("unforced read-back bits lost");

    property p_denied_only_fdc;
        !host_access_select || mode_host |=> !host_denied;
    endproperty
    a_denied_only_fdc: assert property (p_denied_only_fdc) else $error("host denied without floppy owner");

    property p_not_owner;
        !host_access_select || !mode_host |=> host_not_owner;
    endproperty
    a_not_owner: assert property (p_not_owner) else $error("host not-owner flag missing");

    property p_shadow_fdc;
        host_data_write ##1 (!host_data_write && host_access_select && !mode_host)
            |=> host_data_rdata == $past(host_data_wdata, 2);
    endproperty
    a_shadow_fdc: assert property (p_shadow_fdc) else $error("floppy owner data read-back wrong");

    property p_fdc_inputs;
        1'b1 |=> fdc_in == {ec_in.pd[0], ec_in.pd[1], ec_in.pd[2], ec_in.pd[3], ec_in.pd[4]};
    endproperty
    a_fdc_inputs: assert property (p_fdc_inputs) else $error("floppy inputs not taken from data pins");

    property p_fdc_unused;
        owner == PPM_OWN_FDC |-> !port_physical_pins_oe.pd[7] && port_physical_pins_oe.pd[5:0] == 6'h00;
    endproperty
    a_fdc_unused: assert property (p_fdc_unused) else $error("floppy input or unused pin driven");

    property p_fdc_step;
        host_access_select && !mode_host && fdc_activate && !fdc_powerdown
            |=> port_physical_pins_oe.selin == !$past(fdc_out.step_pulse)
            && port_physical_pins_oe.init == !$past(fdc_out.step_direction);
    endproperty
    a_fdc_step: assert property (p_fdc_step) else $error("step lines not on their pins");

    property p_fdc_write;
        host_access_select && !mode_host && fdc_activate && !fdc_powerdown
            |=> port_physical_pins_oe.pe == !$past(fdc_out.write_stream)
            && port_physical_pins_oe.slct == !$past(fdc_out.write_gate);
    endproperty
    a_fdc_write: assert property (p_fdc_write) else $error("write lines not on their pins");

    property p_fdc_head;
        host_access_select && !mode_host && fdc_activate && !fdc_powerdown
            |=> port_physical_pins_oe.autofd == !$past(fdc_out.density_select)
            && port_physical_pins_oe.fault == !$past(fdc_out.head_select);
    endproperty
    a_fdc_head: assert property (p_fdc_head) else $error("density or head line not on its pin");

    property p_fdc_dual;
        host_access_select && device_mode == MODE_FDC_DUAL && fdc_activate && !fdc_powerdown
            |=> port_physical_pins_oe.strobe == !$past(fdc_out.drive_select_zero)
            && port_physical_pins_oe.pd[6] == !$past(fdc_out.motor_on_zero)
            && port_physical_pins_oe.ack == !$past(fdc_out.drive_select_one)
            && port_physical_pins_oe.busy == !$past(fdc_out.motor_on_one);
    endproperty
    a_fdc_dual: assert property (p_fdc_dual) else $error("dual drive pair not on its pins");

    property p_single_swap;
        host_access_select && device_mode == MODE_FDC_SINGLE && drive_swap
            |=> !port_physical_pins_oe.ack && !port_physical_pins_oe.busy;
    endproperty
    a_single_swap: assert property (p_single_swap) else $error("swapped-out drive pair driven");

    // A floppy owner must not be gated by the controller's port-enable bit.
    property p_fdc_port_enable;
        host_access_select && !mode_host && !ec_port_enable && fdc_activate && !fdc_powerdown
            |=> port_physical_pins_oe.slct == !$past(fdc_out.write_gate);
    endproperty
    a_fdc_port_enable: assert property (p_fdc_port_enable) else $error("port-enable gated floppy pins");

endmodule

// [core/ppm_pkg.sv]
package ppm_pkg;

    // Ownership of the connector pins.
    typedef enum logic [1:0] {
        PPM_OWN_HOST,
        PPM_OWN_FDC,
        PPM_OWN_EC
    } ppm_owner_t;

    // Device-mode field encodings.
    localparam logic [1:0] MODE_HOST_LO = 2'h0;
    localparam logic [1:0] MODE_HOST_HI = 2'h3;
    localparam logic [1:0] MODE_FDC_SINGLE = 2'h1;
    localparam logic [1:0] MODE_FDC_DUAL = 2'h2;

    // Host register read-back when the host does not own the pins.
    localparam logic [7:0] CTRL_KEEP_MASK = 8'hf0;
    localparam logic [7:0] CTRL_NO_CABLE = 8'h04;
    localparam logic [7:0] STAT_KEEP_MASK = 8'h07;
    localparam logic [7:0] STAT_NO_CABLE = 8'h48;

    // Floppy outputs are open drain and sink this current in milliamps.
    localparam int FDC_SINK_MA = 14;

    localparam int SYNC_STAGES = 2;
    localparam int PIN_COUNT = 17;
    localparam logic [PIN_COUNT-1:0] PINS_ZERO = 17'h0_0000;

    // One bit per connector pin, in connector order from the top down.
    typedef struct packed {
        logic strobe;
        logic [7:0] pd;
        logic ack;
        logic busy;
        logic pe;
        logic slct;
        logic autofd;
        logic fault;
        logic init;
        logic selin;
    } ppm_pins_t;

    // Floppy controller outputs, as wire levels (active low).
    typedef struct packed {
        logic drive_select_zero;
        logic drive_select_one;
        logic motor_on_zero;
        logic motor_on_one;
        logic write_stream;
        logic write_gate;
        logic density_select;
        logic head_select;
        logic step_direction;
        logic step_pulse;
    } ppm_fdc_out_t;

    // Floppy drive inputs, as wire levels (active low).
    typedef struct packed {
        logic index_pulse;
        logic track_zero;
        logic write_protect;
        logic read_stream;
        logic disk_change;
    } ppm_fdc_in_t;

endpackage

// [core/ppm_sync.sv]
module ppm_sync
    import ppm_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // The first stage feeds only the second stage.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta[i] <= d[i];
                    q[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule

// [core/ppm_fdc_map.sv]
module ppm_fdc_map
    import ppm_pkg::*;
(
    input wire ppm_fdc_out_t fdc_out,
    input wire logic enable,
    input wire logic single,
    input wire logic drive_swap,
    input wire ppm_pins_t pin_sync,
    output ppm_pins_t sink_oe,
    output ppm_fdc_in_t fdc_in
);

    ppm_pins_t low_level;
    logic pair0_on;
    logic pair1_on;

    // Single-drive mode keeps only one select/motor pair; the swap picks it.
    assign pair0_on = !single || drive_swap;
    assign pair1_on = !single || !drive_swap;

    always_comb begin
        low_level = PINS_ZERO;
        low_level.strobe = pair0_on && !fdc_out.drive_select_zero;
        low_level.pd[6] = pair0_on && !fdc_out.motor_on_zero;
        low_level.ack = pair1_on && !fdc_out.drive_select_one;
        low_level.busy = pair1_on && !fdc_out.motor_on_one;
        low_level.pe = !fdc_out.write_stream;
        low_level.slct = !fdc_out.write_gate;
        low_level.autofd = !fdc_out.density_select;
        low_level.fault = !fdc_out.head_select;
        low_level.init = !fdc_out.step_direction;
        low_level.selin = !fdc_out.step_pulse;
    end

    // Open drain: the pin is only ever pulled low, never driven high.
    assign sink_oe = enable ? low_level : PINS_ZERO;

    assign fdc_in.index_pulse = pin_sync.pd[0];
    assign fdc_in.track_zero = pin_sync.pd[1];
    assign fdc_in.write_protect = pin_sync.pd[2];
    assign fdc_in.read_stream = pin_sync.pd[3];
    assign fdc_in.disk_change = pin_sync.pd[4];

endmodule

// [sim/ppm_drive_model.sv]
module ppm_drive_model
    import ppm_pkg::*;
(
    input wire ppm_pins_t pins_out,
    input wire ppm_pins_t pins_oe,
    input wire logic drive_on,
    input wire ppm_fdc_in_t drive_lines,
    output ppm_pins_t pins_in
);
    timeunit 1ns;
    timeprecision 1ns;
    ppm_pins_t idle;
    // Released lines rise to the pull-ups that the open-drain outputs rely on.
    // The model reads no drive-select pair, so an inactive pair stays unconnected.
    always_comb begin
        idle = '1;
        if (drive_on) begin
            idle.pd[4:0] = {drive_lines.disk_change, drive_lines.read_stream, drive_lines.write_protect,
                drive_lines.track_zero, drive_lines.index_pulse};
        end
        pins_in = (pins_out & pins_oe) | (idle & ~pins_oe);
    end
endmodule

// [sim/tb_top.sv]
module tb_top
    import ppm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst, has, supply, swap, f_act, f_pd, h_act, h_pd, ec_en, h_wr, drive_on, denied, not_own;
    logic [1:0] mode;
    logic [7:0] h_wdata, d_nat, c_nat, s_nat, d_rd, c_rd, s_rd;
    ppm_pins_t h_out, h_oe, ec_out, ec_oe, pins_in, pins_out, pins_oe, ec_in;
    ppm_fdc_out_t f_out;
    ppm_fdc_in_t f_in, drv_lines;
    ppm_owner_t own, exp_o;
    int map_pin[10] = '{0, 1, 2, 3, 4, 5, 6, 14, 7, 16};
    int errors = 0;
    int n_tests = 0;

    always #50 clk = ~clk;

    ppm_mux ppm_mux_inst (.clk(clk), .rst(rst), .device_mode(mode), .host_access_select(has),
        .main_supply_good(supply), .drive_swap(swap), .fdc_activate(f_act), .fdc_powerdown(f_pd),
        .host_activate(h_act), .host_powerdown(h_pd), .ec_port_enable(ec_en), .host_out(h_out),
        .host_oe(h_oe), .host_data_write(h_wr), .host_data_wdata(h_wdata), .host_data_native(d_nat),
        .host_ctrl_native(c_nat), .host_status_native(s_nat), .fdc_out(f_out), .ec_out(ec_out),
        .ec_oe(ec_oe), .port_physical_pins_in(pins_in), .port_physical_pins_out(pins_out),
        .port_physical_pins_oe(pins_oe), .owner(own), .host_denied(denied), .host_not_owner(not_own),
        .host_data_rdata(d_rd), .host_ctrl_rdata(c_rd), .host_status_rdata(s_rd), .fdc_in(f_in),
        .ec_in(ec_in));

    ppm_drive_model ppm_drive_model_inst (.pins_out(pins_out), .pins_oe(pins_oe), .drive_on(drive_on),
        .drive_lines(drv_lines), .pins_in(pins_in));

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic host_write(input logic [7:0] v);
        h_wdata = v;
        h_wr = 1'b1;
        step(1);
        h_wr = 1'b0;
    endtask

    task automatic chk_pins(input ppm_pins_t got, input ppm_pins_t exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t pins %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t byte %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_own(input ppm_owner_t eo, input logic ed, input logic en);
        n_tests++;
        if (own !== eo || denied !== ed || not_own !== en) begin
            errors++;
            $display("BAD t=%0t owner %0d %b %b", $time, own, denied, not_own);
        end
    endtask

    task automatic stop_test;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        errors++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        {has, swap, f_act, f_pd, h_act, h_pd, h_wr, drive_on} = 8'h00;
        {supply, ec_en} = 2'h3;
        mode = MODE_HOST_LO;
        {h_wdata, d_nat, c_nat, s_nat} = 32'h0000_0000;
        {h_out, h_oe} = 34'h0_0000_0000;
        {ec_out, ec_oe} = 34'h0_0000_0000;
        f_out = 10'h3ff;
        drv_lines = 5'h16;
        step(4);
        rst = 1'b0;
        chk_own(PPM_OWN_EC, 1'b0, 1'b1);
        chk_pins(pins_oe, PINS_ZERO);
        chk_byte(c_rd, 8'h04);
        chk_byte(s_rd, 8'h48);
        for (int i = 0; i < 8; i++) begin
            has = i[2];
            mode = i[1:0];
            step(1);
            exp_o = !has ? PPM_OWN_EC :
                    (mode == MODE_FDC_SINGLE || mode == MODE_FDC_DUAL) ? PPM_OWN_FDC : PPM_OWN_HOST;
            chk_own(exp_o, exp_o == PPM_OWN_FDC, exp_o != PPM_OWN_HOST);
        end
        has = 1'b0;
        ec_out = 17'h0_a5c3;
        ec_oe = 17'h1_ffff;
        step(4);
        chk_pins(pins_out, ec_out);
        chk_pins(ec_in, ec_out);
        ec_en = 1'b0;
        step(1);
        chk_pins(pins_oe, ec_oe);
        supply = 1'b0;
        step(3);
        chk_pins(pins_oe, PINS_ZERO);
        {d_nat, c_nat, s_nat} = 24'h3c_ffff;
        host_write(8'ha5);
        step(2);
        chk_byte(d_rd, 8'ha5);
        chk_byte(c_rd, 8'hf4);
        chk_byte(s_rd, 8'h4f);
        {supply, ec_en, has, h_act} = 4'hf;
        mode = MODE_HOST_LO;
        h_out = 17'h1_2345;
        h_oe = 17'h1_ffff;
        step(1);
        chk_pins(pins_out, h_out);
        chk_pins(pins_oe, h_oe);
        chk_byte(d_rd, d_nat);
        chk_byte(c_rd, c_nat);
        chk_byte(s_rd, s_nat);
        h_pd = 1'b1;
        step(1);
        chk_pins(pins_oe, PINS_ZERO);
        h_pd = 1'b0;
        ec_en = 1'b0;
        step(1);
        chk_pins(pins_oe, PINS_ZERO);
        ec_en = 1'b1;
        // Software silences the host port before the floppy takes the pins.
        h_act = 1'b0;
        step(1);
        chk_pins(pins_oe, PINS_ZERO);
        {f_act, drive_on} = 2'h3;
        f_out = 10'h000;
        mode = MODE_FDC_DUAL;
        step(1);
        chk_pins(pins_oe, 17'h1_40ff);
        chk_pins(pins_out, PINS_ZERO);
        chk_byte(c_rd, 8'hf4);
        chk_own(PPM_OWN_FDC, 1'b1, 1'b1);
        host_write(8'h5a);
        step(2);
        chk_byte(d_rd, 8'h5a);
        chk_byte({3'h0, f_in}, 8'h16);
        for (int k = 0; k < 10; k++) begin
            f_out = ~(10'h001 << k);
            step(1);
            chk_pins(pins_oe, 17'h0_0001 << map_pin[k]);
        end
        f_out = 10'h000;
        ec_en = 1'b0;
        step(1);
        chk_pins(pins_oe, 17'h1_40ff);
        ec_en = 1'b1;
        mode = MODE_FDC_SINGLE;
        step(1);
        chk_pins(pins_oe, 17'h0_00ff);
        swap = 1'b1;
        step(1);
        chk_pins(pins_oe, 17'h1_403f);
        f_pd = 1'b1;
        step(1);
        chk_pins(pins_oe, PINS_ZERO);
        f_pd = 1'b0;
        f_act = 1'b0;
        step(1);
        chk_pins(pins_oe, PINS_ZERO);
        stop_test();
    end
endmodule
